/* src/bts_defs.vh */
`ifndef BTS_DEFS_VH
`define BTS_DEFS_VH
// ********************************************************************
// register byte offsets and decode areas
// ********************************************************************
`define BTS_AW 7
`define BTS_OFS_CTRL 7'h00
`define BTS_OFS_STATUS 7'h04
`define BTS_OFS_RESTART 7'h08
`define BTS_OFS_SETUP 7'h0c
`define BTS_AREA_HI 6
`define BTS_AREA_LO 5
`define BTS_IDX_HI 4
`define BTS_IDX_LO 2
`define BTS_AREA_PRIM 2'h1
`define BTS_AREA_SEC 2'h2
// ********************************************************************
// qualifier word fields
// ********************************************************************
`define BTS_QW 12
`define BTS_Q_MASK 7:0
`define BTS_Q_ARM 8
`define BTS_Q_MODE 11:10
`define BTS_QM_NEVER 2'h0
`define BTS_QM_ANY 2'h1
`define BTS_QM_EXPR 2'h2
`define BTS_Q_NEVER 12'h000
`define BTS_Q_ANY 12'h400
`define BTS_CNT 31:16
`define BTS_CNT_ONE 16'h0001
`define BTS_DEST 18:16
`define BTS_DEST_SET 19
// ********************************************************************
// control and status fields
// ********************************************************************
`define BTS_C_CPLX 0
`define BTS_C_TRIG 6:4
`define BTS_C_ARMSEL 8
`define BTS_C_INIT 16
`define BTS_C_SETUP 17
`define BTS_S_TERM 2:0
`define BTS_S_TRIGD 4
`define BTS_S_ARM 5
`define BTS_RST_TRIG 3'h1
`define BTS_TERM_FIRST 3'h0
`define BTS_TERM_LAST 3'h7
`define BTS_TERM_STEP 3'h1
`endif

/* src/bts_sequencer.v */
// Contract
// RULE1: always eight terms, each with own primary and secondary qualifier.
// RULE2: easy mode uses one shared restart; complex mode per-term secondaries.
// RULE3: easy mode restart match returns sequencer to term 1 from anywhere.
// RULE4: complex secondary match jumps to programmed destination, any term.
// RULE5: unprogrammed destination defaults to current term plus one.
// RULE6: term 8 default destination is term 8 itself.
// RULE7: primary and secondary on same state: primary branch wins.
// RULE8: otherwise whichever qualifier is met first decides the branch.
// RULE9: secondary branch clears primary occurrence counter, even to same term.
// RULE10: primary satisfied only after programmed occurrence count; default one.
// RULE11: every qualifier offers always-satisfied and never-satisfied settings.
// RULE12: power-up or initialize sets all secondary qualifiers to never.
// RULE13: complex qualifier may OR several pattern matches on one state.
// RULE14: trigger declared on reaching programmable trigger term.
// RULE15: arm from either cross-trigger line usable inside secondary qualifier.
// RULE16: each state that caused a branch carries a branch marker.
// RULE17: arm starts false, latches true on first rising edge of source.
// RULE18: simple trigger setup loads term 1 primary and sets restart never; in complex mode the code sets term 2 secondary never instead.
// RULE19: qualifiers evaluated and term updated once per captured state.
// RULE20: entering a new term clears its occurrence counter.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.vh"

module bts_sequencer #(
    parameter NPAT = 8,
    parameter CW = 16
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire [6:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire state_valid,
    input wire [NPAT-1:0] pattern_match,
    input wire cross_trigger_line_a,
    input wire cross_trigger_line_b,
    output wire [2:0] cur_term,
    output wire trigger_pulse,
    output wire triggered,
    output wire arm,
    output wire state_out_valid,
    output wire branch_marker
);

// ********************************************************************
// helpers
// ********************************************************************
function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    reg [31:0] m;
    begin
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~m) | (wd & m);
    end
endfunction

// RULE11: any and never settings
// RULE13: or of pattern matches
function hit;
    input [`BTS_QW-1:0] q;
    input [NPAT-1:0] pm;
    input armv;
    begin
        case (q[`BTS_Q_MODE])
            `BTS_QM_ANY: hit = 1'b1;
            `BTS_QM_EXPR: hit = (|(q[`BTS_Q_MASK] & pm[7:0])) | (q[`BTS_Q_ARM] & armv);
            default: hit = 1'b0;
        endcase
    end
endfunction

// ********************************************************************
// storage
// ********************************************************************
reg [`BTS_QW-1:0] pq_ff [0:7];
reg [CW-1:0] pc_ff [0:7];
reg [`BTS_QW-1:0] sq_ff [0:7];
reg [2:0] sd_ff [0:7];
reg sdv_ff [0:7];
reg [`BTS_QW-1:0] rq_ff;
reg [31:0] setup_ff;
reg cplx_ff;
reg [2:0] trig_term_ff;
reg arm_sel_ff;
reg [2:0] term_ff;
reg [CW-1:0] cnt_ff;
reg trigd_ff;
reg trig_pulse_ff;
reg arm_ff;
reg src_prev_ff;
reg out_valid_ff;
reg mark_ff;
reg ack_ff;
reg [31:0] rdata_ff;
integer i;

// ********************************************************************
// bus decode
// ********************************************************************
wire req = avs_read | avs_write;
wire [1:0] area = avs_address[`BTS_AREA_HI:`BTS_AREA_LO];
wire [2:0] idx = avs_address[`BTS_IDX_HI:`BTS_IDX_LO];
wire wr_go = avs_write & ack_ff & ce;
wire is_ctrl = avs_address == `BTS_OFS_CTRL;
wire is_rst = avs_address == `BTS_OFS_RESTART;
wire is_setup = avs_address == `BTS_OFS_SETUP;
wire is_prim = area == `BTS_AREA_PRIM;
wire is_sec = area == `BTS_AREA_SEC;

reg [31:0] ctrl_rd;
reg [31:0] stat_rd;
reg [31:0] prim_rd;
reg [31:0] sec_rd;
reg [31:0] rd_mux;
always @* begin
    ctrl_rd = 32'h0;
    ctrl_rd[`BTS_C_CPLX] = cplx_ff;
    ctrl_rd[`BTS_C_TRIG] = trig_term_ff;
    ctrl_rd[`BTS_C_ARMSEL] = arm_sel_ff;
    stat_rd = 32'h0;
    stat_rd[`BTS_S_TERM] = term_ff;
    stat_rd[`BTS_S_TRIGD] = trigd_ff;
    stat_rd[`BTS_S_ARM] = arm_ff;
    prim_rd = 32'h0;
    prim_rd[`BTS_QW-1:0] = pq_ff[idx];
    prim_rd[`BTS_CNT] = pc_ff[idx];
    sec_rd = 32'h0;
    sec_rd[`BTS_QW-1:0] = sq_ff[idx];
    sec_rd[`BTS_DEST] = sd_ff[idx];
    sec_rd[`BTS_DEST_SET] = sdv_ff[idx];
    if (is_ctrl) begin
        rd_mux = ctrl_rd;
    end else if (avs_address == `BTS_OFS_STATUS) begin
        rd_mux = stat_rd;
    end else if (is_rst) begin
        rd_mux = {20'h0, rq_ff};
    end else if (is_setup) begin
        rd_mux = setup_ff;
    end else if (is_prim) begin
        rd_mux = prim_rd;
    end else if (is_sec) begin
        rd_mux = sec_rd;
    end else begin
        rd_mux = 32'h0;
    end
end

// one wait state: write taken at the edge where ack_ff is high, read data latched at the edge before
assign avs_waitrequest = req & ~ack_ff;
assign avs_readdata = rdata_ff;

always @(posedge clk) begin
    if (srst) begin
        ack_ff <= 1'b0;
        rdata_ff <= 32'h0;
    end else if (ce) begin
        ack_ff <= req & ~ack_ff;
        if (avs_read & ~ack_ff) begin
            rdata_ff <= rd_mux;
        end
    end
end

// ********************************************************************
// command decode
// ********************************************************************
wire [31:0] ctrl_new = merge(ctrl_rd, avs_writedata, avs_byteenable);
wire [31:0] rst_new = merge({20'h0, rq_ff}, avs_writedata, avs_byteenable);
wire [31:0] prim_new = merge(prim_rd, avs_writedata, avs_byteenable);
wire [31:0] sec_new = merge(sec_rd, avs_writedata, avs_byteenable);
wire init_cmd = wr_go & is_ctrl & ctrl_new[`BTS_C_INIT];
wire setup_cmd = wr_go & is_ctrl & ctrl_new[`BTS_C_SETUP];
wire do_init = srst | init_cmd;

// ********************************************************************
// arm latch
// ********************************************************************
wire arm_src = arm_sel_ff ? cross_trigger_line_b : cross_trigger_line_a;

always @(posedge clk) begin
    if (ce) begin
        src_prev_ff <= arm_src;
        // RULE17: latch on first rise
        if (do_init) begin
            arm_ff <= 1'b0;
        end else if (arm_src & ~src_prev_ff) begin
            arm_ff <= 1'b1;
        end
    end
end

// ********************************************************************
// qualifier evaluation
// ********************************************************************
wire [`BTS_QW-1:0] cur_pq = pq_ff[term_ff];
wire [CW-1:0] cur_pc = pc_ff[term_ff];
wire prim_hit = hit(cur_pq, pattern_match, arm_ff);
// RULE2: shared restart or per-term secondary
// RULE15: arm feeds secondary qualifier
wire sec_hit = cplx_ff ? hit(sq_ff[term_ff], pattern_match, arm_ff)
                       : hit(rq_ff, pattern_match, arm_ff);
wire [CW-1:0] cnt_inc = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
// RULE10: satisfied at programmed count, zero acts as one
wire prim_done = prim_hit & ((cnt_inc >= cur_pc) | (cur_pc == {CW{1'b0}}));

reg [2:0] dflt_dest;
reg [2:0] sec_dest;
always @* begin
    // RULE5: default next term
    // RULE6: term 8 stays
    if (term_ff == `BTS_TERM_LAST) begin
        dflt_dest = `BTS_TERM_LAST;
    end else begin
        dflt_dest = term_ff + `BTS_TERM_STEP;
    end
    // RULE3: easy restart to term 1
    // RULE4: programmed destination
    if (!cplx_ff) begin
        sec_dest = `BTS_TERM_FIRST;
    end else if (sdv_ff[term_ff]) begin
        sec_dest = sd_ff[term_ff];
    end else begin
        sec_dest = dflt_dest;
    end
end

wire prim_dest_is_last = term_ff == `BTS_TERM_LAST;
wire [2:0] prim_dest = prim_dest_is_last ? `BTS_TERM_LAST : term_ff + `BTS_TERM_STEP;

// ********************************************************************
// sequencer
// ********************************************************************
reg [2:0] nxt_term;
reg [CW-1:0] nxt_cnt;
reg nxt_branch;
always @* begin
    nxt_term = term_ff;
    nxt_cnt = cnt_ff;
    nxt_branch = 1'b0;
    // RULE7: primary wins on tie
    // RULE8: first met decides
    if (prim_done) begin
        nxt_term = prim_dest;
        // RULE20: fresh count on entry
        nxt_cnt = {CW{1'b0}};
        nxt_branch = 1'b1;
    end else if (sec_hit) begin
        nxt_term = sec_dest;
        // RULE9: clear occurrence count
        nxt_cnt = {CW{1'b0}};
        nxt_branch = 1'b1;
    end else if (prim_hit) begin
        nxt_cnt = cnt_inc;
    end
end

always @(posedge clk) begin
    if (do_init & ce) begin
        term_ff <= `BTS_TERM_FIRST;
        cnt_ff <= {CW{1'b0}};
        trigd_ff <= 1'b0;
        trig_pulse_ff <= 1'b0;
        out_valid_ff <= 1'b0;
        mark_ff <= 1'b0;
    end else if (ce & setup_cmd) begin
        term_ff <= `BTS_TERM_FIRST;
        cnt_ff <= {CW{1'b0}};
        trigd_ff <= 1'b0;
        trig_pulse_ff <= 1'b0;
        out_valid_ff <= 1'b0;
        mark_ff <= 1'b0;
    end else if (ce) begin
        // RULE19: one step per captured state
        out_valid_ff <= state_valid;
        mark_ff <= state_valid & nxt_branch;
        trig_pulse_ff <= 1'b0;
        if (state_valid) begin
            term_ff <= nxt_term;
            cnt_ff <= nxt_cnt;
            // RULE14: trigger on reaching trigger term
            if (nxt_branch & (nxt_term == trig_term_ff) & ~trigd_ff) begin
                trigd_ff <= 1'b1;
                trig_pulse_ff <= 1'b1;
            end
        end
    end
end

// ********************************************************************
// configuration registers
// ********************************************************************
always @(posedge clk) begin
    if (do_init & ce) begin
        cplx_ff <= 1'b0;
        trig_term_ff <= `BTS_RST_TRIG;
        arm_sel_ff <= 1'b0;
        // RULE12: secondaries never after init
        rq_ff <= `BTS_Q_NEVER;
        setup_ff <= 32'h0;
        for (i = 0; i < 8; i = i + 1) begin
            sq_ff[i] <= `BTS_Q_NEVER;
            sd_ff[i] <= `BTS_TERM_FIRST;
            sdv_ff[i] <= 1'b0;
            pq_ff[i] <= (i == 0) ? `BTS_Q_ANY : `BTS_Q_NEVER;
            pc_ff[i] <= `BTS_CNT_ONE;
        end
    end else if (ce & setup_cmd) begin
        // RULE18: simple trigger setup
        pq_ff[0] <= setup_ff[`BTS_QW-1:0];
        pc_ff[0] <= setup_ff[`BTS_CNT];
        trig_term_ff <= `BTS_RST_TRIG;
        if (cplx_ff) begin
            sq_ff[1] <= `BTS_Q_NEVER;
        end else begin
            rq_ff <= `BTS_Q_NEVER;
        end
    end else if (wr_go) begin
        if (is_ctrl) begin
            cplx_ff <= ctrl_new[`BTS_C_CPLX];
            trig_term_ff <= ctrl_new[`BTS_C_TRIG];
            arm_sel_ff <= ctrl_new[`BTS_C_ARMSEL];
        end
        if (is_rst) begin
            rq_ff <= rst_new[`BTS_QW-1:0];
        end
        if (is_setup) begin
            setup_ff <= merge(setup_ff, avs_writedata, avs_byteenable);
        end
        // RULE1: eight independent terms
        if (is_prim) begin
            pq_ff[idx] <= prim_new[`BTS_QW-1:0];
            pc_ff[idx] <= prim_new[`BTS_CNT];
        end
        if (is_sec) begin
            sq_ff[idx] <= sec_new[`BTS_QW-1:0];
            sd_ff[idx] <= sec_new[`BTS_DEST];
            sdv_ff[idx] <= sec_new[`BTS_DEST_SET];
        end
    end
end

// ********************************************************************
// outputs
// ********************************************************************
assign cur_term = term_ff;
assign triggered = trigd_ff;
assign trigger_pulse = trig_pulse_ff;
assign arm = arm_ff;
assign state_out_valid = out_valid_ff;
// RULE16: branch marker with state
assign branch_marker = mark_ff;

endmodule // bts_sequencer
`default_nettype wire

/* testbench/bts_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************
// emulated bus: one state per call
// ********************************
module bts_bus_model (
    input wire logic clk,
    output logic state_valid,
    output logic [7:0] pattern_match
);
    initial begin
        state_valid = 1'b0;
        pattern_match = 8'h00;
    end
    // idle match lines show the inverse so stale values never pass
    task automatic send(input logic [7:0] p, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        state_valid <= 1'b1;
        pattern_match <= p;
        @(posedge clk);
        state_valid <= 1'b0;
        pattern_match <= ~p;
    endtask
endmodule // bts_bus_model
`default_nettype wire

/* testbench/bts_seq_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************
// sequencer port checks
// ********************************
module bts_seq_chk (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire state_valid,
    input wire [2:0] cur_term,
    input wire trigger_pulse,
    input wire triggered,
    input wire arm,
    input wire state_out_valid,
    input wire branch_marker
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire req = avs_read | avs_write;
    wire wr_done = avs_write & ~avs_waitrequest;
    first_wait_a: assert property (ce && req && !$past(req) |-> avs_waitrequest)
        else $error("request answered at once");
    one_wait_a: assert property (ce && req && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    idle_wait_a: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest with no request");
    pass_state_a: assert property (ce && state_valid && !wr_done |=> state_out_valid)
        else $error("captured state not passed on");
    term_hold_a: assert property (!state_valid && !wr_done |=> $stable(cur_term))
        else $error("term moved with no state");
    branch_mark_a: assert property (
        $changed(cur_term) && $past(state_valid) |-> branch_marker)
        else $error("branch not marked");
    pulse_mark_a: assert property (trigger_pulse |-> branch_marker && triggered)
        else $error("trigger pulse without branch");
    pulse_once_a: assert property (triggered && $past(triggered) |-> !trigger_pulse)
        else $error("second trigger pulse");
    arm_hold_a: assert property (arm && !wr_done |=> arm)
        else $error("arm dropped");
endmodule // bts_seq_chk
bind bts_sequencer bts_seq_chk i_chk (.clk(clk), .srst(srst), .ce(ce), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .state_valid(state_valid),
    .cur_term(cur_term), .trigger_pulse(trigger_pulse), .triggered(triggered), .arm(arm),
    .state_out_valid(state_out_valid), .branch_marker(branch_marker));
`default_nettype wire

/* testbench/test_bus_trace_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.vh"
// ********************************
// sequencer bench
// ********************************
module test_bus_trace_sequencer;
    logic clk, srst, ce, rd, wr, line_a, line_b, cplx, armv, trgd;
    logic [6:0] adr;
    logic [31:0] wdat, seed, su;
    logic [11:0] pq[8], sq[8], rq;
    logic [15:0] pc[8];
    logic [3:0] sd[8];
    logic [2:0] term, trig;
    int cnt, err_total, comparisons;
    wire [31:0] rdat;
    wire [7:0] pat;
    wire [2:0] cur_term;
    wire waitreq, sv, tp, trg, arm, ov, mk;
    bts_bus_model i_bus (.clk(clk), .state_valid(sv), .pattern_match(pat));
    bts_sequencer i_dut (.clk(clk), .srst(srst), .ce(ce), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(waitreq), .state_valid(sv), .pattern_match(pat),
        .cross_trigger_line_a(line_a), .cross_trigger_line_b(line_b), .cur_term(cur_term),
        .trigger_pulse(tp), .triggered(trg), .arm(arm), .state_out_valid(ov), .branch_marker(mk));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic qm(input logic [11:0] q, input logic [7:0] p);
        return q[11:10] == 2'h1 || (q[11:10] == 2'h2 && ((|(q[7:0] & p)) || (q[8] && armv)));
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic is_wr, input logic [6:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        {rd, wr, adr, wdat} <= {!is_wr, is_wr, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 40);
        q = rdat;
        {rd, wr} <= 2'b00;
        if (n >= 40) cmp(32'h0, 32'h1);
    endtask
    task automatic minit();
        for (int i = 0; i < 8; i++) begin
            {pq[i], sq[i], pc[i], sd[i]} = {`BTS_Q_NEVER, `BTS_Q_NEVER, `BTS_CNT_ONE, 4'h0};
        end
        pq[0] = `BTS_Q_ANY;
        {rq, cplx, trig, term, trgd, armv} = {12'h0, 1'b0, `BTS_RST_TRIG, 3'h0, 2'h0};
        cnt = 0;
    endtask
    task automatic w(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        if (a[6:5] == `BTS_AREA_PRIM) {pq[a[4:2]], pc[a[4:2]]} = {d[11:0], d[31:16]};
        if (a[6:5] == `BTS_AREA_SEC) {sq[a[4:2]], sd[a[4:2]]} = {d[11:0], d[19:16]};
        if (a == `BTS_OFS_RESTART) rq = d[11:0];
        if (a == `BTS_OFS_SETUP) su = d;
        if (a == `BTS_OFS_CTRL) begin
            if (d[`BTS_C_INIT]) begin
                minit();
            end else if (d[`BTS_C_SETUP]) begin
                {pq[0], pc[0], term, trgd, trig} = {su[11:0], su[31:16], 4'h0, `BTS_RST_TRIG};
                if (cplx) sq[1] = `BTS_Q_NEVER;
                else rq = `BTS_Q_NEVER;
                cnt = 0;
            end else begin
                {trig, cplx} = {d[6:4], d[0]};
            end
        end
    endtask
    task automatic r(input logic [6:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(q, e);
    endtask
    task automatic st(input logic [7:0] p);
        logic hit, pul;
        logic [2:0] nt;
        i_bus.send(p, int'(xs() % 3));
        hit = 1'b0;
        nt = (term == 3'h7) ? term : term + 3'h1;
        if (qm(pq[term], p)) begin
            cnt++;
            hit = cnt >= ((pc[term] == 16'h0) ? 1 : int'(pc[term]));
        end
        if (!hit && qm(cplx ? sq[term] : rq, p)) begin
            hit = 1'b1;
            nt = !cplx ? 3'h0 : sd[term][3] ? sd[term][2:0] : nt;
        end
        pul = hit && nt == trig && !trgd;
        trgd = trgd | pul;
        if (hit) {cnt, term} = {32'h0, nt};
        #1;
        cmp({26'h0, cur_term, mk, tp, ov}, {26'h0, term, hit, pul, 1'b1});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
    initial begin
        {srst, ce, rd, wr, line_a, line_b, adr, wdat, seed, su} =
            {6'h30, 7'h0, 32'h0, 32'h2aee, 32'h0};
        {err_total, comparisons} = 64'h0;
        minit();
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        r(`BTS_OFS_STATUS, 32'h0);
        r(`BTS_OFS_CTRL, 32'h10);
        r(`BTS_OFS_RESTART, 32'h0);
        r(7'h5c, 32'h0);
        r(7'h14, 32'h0);
        st(8'h00);
        $display("reset test done");
        w(`BTS_OFS_CTRL, 32'h10010);
        w(7'h20, 32'h30801);
        st(8'h01);
        st(8'h00);
        st(8'h01);
        st(8'h01);
        $display("count test done");
        w(`BTS_OFS_CTRL, 32'h10010);
        w(`BTS_OFS_CTRL, 32'h11);
        w(7'h20, 32'h30801);
        w(7'h40, 32'h80806);
        repeat (2) st(8'h01);
        st(8'h04);
        repeat (2) st(8'h01);
        st(8'h03);
        w(7'h44, 32'hd0900);
        st(8'hff);
        @(posedge clk) line_a <= 1'b1;
        repeat (3) @(posedge clk);
        armv = 1'b1;
        st(8'h00);
        @(posedge clk) line_a <= 1'b0;
        r(`BTS_OFS_STATUS, 32'h35);
        $display("branch test done");
        w(`BTS_OFS_CTRL, 32'h10010);
        w(`BTS_OFS_CTRL, 32'h11);
        w(7'h20, 32'h0);
        for (int i = 0; i < 8; i++) w(7'h40 + 7'(4 * i), 32'h400);
        repeat (9) st(8'(xs()));
        $display("default destination test done");
        w(`BTS_OFS_CTRL, 32'h10010);
        w(`BTS_OFS_RESTART, 32'h810);
        w(`BTS_OFS_SETUP, 32'h20808);
        w(`BTS_OFS_CTRL, 32'h20010);
        r(`BTS_OFS_RESTART, 32'h0);
        repeat (2) st(8'h08);
        w(`BTS_OFS_RESTART, 32'h810);
        w(7'h24, 32'h10400);
        st(8'h00);
        st(8'h10);
        $display("easy test done");
        w(`BTS_OFS_CTRL, 32'h10010);
        w(`BTS_OFS_CTRL, 32'h110);
        @(posedge clk) line_a <= 1'b1;
        r(`BTS_OFS_STATUS, 32'h0);
        @(posedge clk) line_b <= 1'b1;
        r(`BTS_OFS_STATUS, 32'h20);
        $display("arm select test done");
        w(`BTS_OFS_CTRL, 32'h10010);
        w(`BTS_OFS_CTRL, 32'h11);
        for (int i = 0; i < 8; i++) begin
            w(7'h20 + 7'(4 * i), {16'(xs() % 3 + 1), 8'h08, 8'(xs())});
            w(7'h40 + 7'(4 * i), {12'h0, 4'(xs()), 8'h08, 8'(xs())});
        end
        repeat (60) st(8'(xs()));
        $display("random test done");
        @(posedge clk) ce <= 1'b0;
        i_bus.send(8'hff, 0);
        #1;
        cmp({26'h0, cur_term, mk, tp, ov}, {26'h0, term, 3'h0});
        @(posedge clk) ce <= 1'b1;
        $display("clock enable test done");
        end_of_test();
    end
endmodule // test_bus_trace_sequencer
`default_nettype wire
